// >>> rtcsr_host.sv
// host model: one-cycle register strobes toward the status block
`timescale 1ns/1ps
`default_nettype none
module rtcsr_host (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // callers read right after a tick
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    repeat (4) if (reg_rvalid !== 1'b1) @(posedge sys_clk);
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

// >>> rtcsr_pkg.sv
// package: register offsets, bit positions and reset values of the rtc status block
package rtcsr_pkg;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h0D;
  localparam logic [7:0] ADDR_TEMP_FRAC = 8'h0E;
  localparam logic [7:0] ADDR_TEMP_INT = 8'h0F;
  localparam int EVB_LOW_VOLTAGE = 0;
  localparam int EVB_POWER_ON = 1;
  localparam int EVB_EXT_EVENT = 2;
  localparam int EVB_ALARM = 3;
  localparam int EVB_COUNTDOWN = 4;
  localparam int EVB_UPDATE = 5;
  localparam int EVB_TEMP_LOW = 6;
  localparam int TFB_BACKUP = 0;
  localparam int TFB_CLOCK_OUTPUT_PIN = 1;
  localparam int TFB_NVM_BUSY = 2;
  localparam int TFB_NVM_FAIL = 3;
  localparam logic [7:0] EVENT_RESET = 8'h02;
  localparam logic [3:0] TFLAG_RESET = 4'h0;
  localparam logic [11:0] TEMP_RESET = 12'h000;
  localparam logic [1:0] BSEL_OFF_A = 2'h0;
  localparam logic [1:0] BSEL_OFF_B = 2'h3;
  localparam int SYNC_STAGES = 2;
endpackage

// >>> rtcsr_regs.sv
// status flags and thermometer registers of the real-time clock
`timescale 1ns/1ps
`default_nettype none
module rtcsr_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic write_locked,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic second_tick,
  input wire logic clock_stopped,
  input wire logic [11:0] temp_measure,
  input wire logic calendar_step,
  input wire logic alarm_match,
  input wire logic countdown_evt,
  input wire logic update_evt,
  input wire logic ext_event_pin,
  input wire logic temp_low_evt,
  input wire logic supply_below_vlow,
  input wire logic nvm_abort_low,
  input wire logic nvm_busy_in,
  input wire logic clock_output_pin_irq_on,
  input wire logic backup_switched,
  input wire logic [1:0] backup_switch_select,
  output logic comp_halt,
  output logic clock_output_pin_force_low,
  output logic bus_disable
);
  import rtcsr_pkg::*;

  logic ext_event_sync;
  logic low_sync;
  logic ext_prev_ff;
  logic alarm_prev_ff;
  logic [11:0] temp_ff;
  logic nvm_busy_ff;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  logic comp_halt_ff;
  logic clock_output_pin_low_ff;
  logic bus_dis_ff;
  logic por_ff;
  logic [6:0] ev_flag;
  logic [6:0] ev_set;
  logic [6:0] ev_clr;
  logic [1:0] tf_flag;
  logic [1:0] tf_set;
  logic [1:0] tf_clr;
  logic wr_ok;
  logic bsel_on;

  rtcsr_sync u_sync_ext (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(ext_event_pin),
    .dout(ext_event_sync)
  );

  rtcsr_sync u_sync_low (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(supply_below_vlow),
    .dout(low_sync)
  );

  // power-on flag reads one from reset until the host clears it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_ff <= 1'b1;
    end else if (wr_ok && reg_addr == ADDR_EVENT_FLAGS && !reg_wdata[EVB_POWER_ON]) begin
      por_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_prev_ff <= 1'b0;
      alarm_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_event_sync;
      alarm_prev_ff <= alarm_match;
    end
  end

  assign wr_ok = reg_wr && !write_locked && !low_sync;
  assign bsel_on = backup_switch_select != BSEL_OFF_A && backup_switch_select != BSEL_OFF_B;

  assign ev_set[EVB_ALARM] = calendar_step && alarm_match && !alarm_prev_ff;
  assign ev_set[EVB_LOW_VOLTAGE] = low_sync;
  assign ev_set[EVB_POWER_ON] = 1'b0;
  assign ev_set[EVB_EXT_EVENT] = ext_event_sync && !ext_prev_ff;
  assign ev_set[EVB_COUNTDOWN] = countdown_evt;
  assign ev_set[EVB_UPDATE] = update_evt;
  assign ev_set[EVB_TEMP_LOW] = temp_low_evt;

  assign tf_set[0] = nvm_abort_low;
  assign tf_set[1] = clock_output_pin_irq_on;

  logic ev_wr;
  logic tf_wr;
  assign ev_wr = wr_ok && reg_addr == ADDR_EVENT_FLAGS;
  assign tf_wr = wr_ok && reg_addr == ADDR_TEMP_FRAC;
  assign ev_clr = {7{ev_wr}} & ~reg_wdata[6:0];
  assign tf_clr[0] = tf_wr && !reg_wdata[TFB_NVM_FAIL];
  assign tf_clr[1] = tf_wr && !reg_wdata[TFB_CLOCK_OUTPUT_PIN];

  // reset clears flag
  // low supply re-sets this flag every cycle it lasts, so a clear only sticks after recovery
  rtcsr_sticky u_flag_low (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(ev_set[EVB_LOW_VOLTAGE]),
    .clr_evt(ev_clr[EVB_LOW_VOLTAGE]),
    .flag(ev_flag[EVB_LOW_VOLTAGE])
  );

  // power-on flag has no hardware set; it reads one through the reset value input
  rtcsr_sticky u_flag_por (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(por_ff),
    .set_evt(ev_set[EVB_POWER_ON]),
    .clr_evt(ev_clr[EVB_POWER_ON]),
    .flag(ev_flag[EVB_POWER_ON])
  );

  // edge is taken after the synchroniser: pin pulses shorter than one clock may be lost
  rtcsr_sticky u_flag_ext (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(ev_set[EVB_EXT_EVENT]),
    .clr_evt(ev_clr[EVB_EXT_EVENT]),
    .flag(ev_flag[EVB_EXT_EVENT])
  );

  rtcsr_sticky u_flag_alarm (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(ev_set[EVB_ALARM]),
    .clr_evt(ev_clr[EVB_ALARM]),
    .flag(ev_flag[EVB_ALARM])
  );

  rtcsr_sticky u_flag_count (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(ev_set[EVB_COUNTDOWN]),
    .clr_evt(ev_clr[EVB_COUNTDOWN]),
    .flag(ev_flag[EVB_COUNTDOWN])
  );

  rtcsr_sticky u_flag_update (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(ev_set[EVB_UPDATE]),
    .clr_evt(ev_clr[EVB_UPDATE]),
    .flag(ev_flag[EVB_UPDATE])
  );

  rtcsr_sticky u_flag_tlow (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(ev_set[EVB_TEMP_LOW]),
    .clr_evt(ev_clr[EVB_TEMP_LOW]),
    .flag(ev_flag[EVB_TEMP_LOW])
  );

  // the two sticky flags of the fraction byte; busy and backup are handled apart
  rtcsr_sticky u_flag_nvm (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(tf_set[0]),
    .clr_evt(tf_clr[0]),
    .flag(tf_flag[0])
  );

  rtcsr_sticky u_flag_clk (
    .sys_clk(sys_clk),
    .rst(rst),
    .rst_val(1'b0),
    .set_evt(tf_set[1]),
    .clr_evt(tf_clr[1]),
    .flag(tf_flag[1])
  );

  logic bsf_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bsf_ff <= 1'b0;
    end else if (!bsel_on) begin
      bsf_ff <= 1'b0;
    end else if (backup_switched) begin
      bsf_ff <= 1'b1;
    end else if (wr_ok && reg_addr == ADDR_TEMP_FRAC && !reg_wdata[TFB_BACKUP]) begin
      bsf_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      temp_ff <= TEMP_RESET;
    end else if (second_tick && !clock_stopped && !low_sync) begin
      temp_ff <= temp_measure;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nvm_busy_ff <= 1'b0;
    end else begin
      nvm_busy_ff <= nvm_busy_in;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comp_halt_ff <= 1'b0;
      clock_output_pin_low_ff <= 1'b0;
      bus_dis_ff <= 1'b0;
    end else begin
      comp_halt_ff <= low_sync;
      clock_output_pin_low_ff <= low_sync;
      bus_dis_ff <= low_sync;
    end
  end

  // read path; unmapped addresses read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd && !low_sync;
      if (reg_rd && !low_sync) begin
        case (reg_addr)
          ADDR_EVENT_FLAGS: reg_rdata_ff <= {1'b0, ev_flag};
          ADDR_TEMP_FRAC: reg_rdata_ff <= {temp_ff[3:0], tf_flag[0], nvm_busy_ff,
            tf_flag[1], bsf_ff};
          ADDR_TEMP_INT: reg_rdata_ff <= temp_ff[11:4];
          default: reg_rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign comp_halt = comp_halt_ff;
  assign clock_output_pin_force_low = clock_output_pin_low_ff;
  assign bus_disable = bus_dis_ff;
endmodule
`default_nettype wire

// >>> rtcsr_regs_bench.sv
// self-checking bench for the status and thermometer registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rtcsr_regs_bench;
  import rtcsr_pkg::*;
  logic sys_clk, rst, write_locked, second_tick, clock_stopped, calendar_step, alarm_match;
  logic countdown_evt, update_evt, ext_event_pin, temp_low_evt, supply_below_vlow;
  logic nvm_abort_low, nvm_busy_in, clock_output_pin_irq_on, backup_switched, reg_wr, reg_rd;
  logic reg_rvalid, comp_halt, clock_output_pin_force_low, bus_disable;
  logic [1:0] backup_switch_select;
  logic [11:0] temp_measure;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int fail_count = 0;
  int compares = 0;
  rtcsr_regs i_rtcsr_regs (.*);
  rtcsr_host i_rtcsr_host (.*);
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_rtcsr_host.rd(a, v);
    `CHK(v, e)
  endtask
  task automatic tick();
    @(posedge sys_clk) second_tick <= 1'b1;
    @(posedge sys_clk) second_tick <= 1'b0;
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // whole run is about a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    results();
  end
  initial begin
    {rst, write_locked, second_tick, clock_stopped, calendar_step, alarm_match} = 6'h20;
    {countdown_evt, update_evt, ext_event_pin, temp_low_evt, supply_below_vlow} = 5'h00;
    {nvm_abort_low, nvm_busy_in, clock_output_pin_irq_on, backup_switched} = 4'h4;
    {backup_switch_select, temp_measure} = {2'h1, 12'hFFC};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    chk(ADDR_EVENT_FLAGS, EVENT_RESET);
    {countdown_evt, update_evt, temp_low_evt} <= 3'h7;
    @(posedge sys_clk) {countdown_evt, update_evt, temp_low_evt} <= 3'h0;
    chk(ADDR_EVENT_FLAGS, 8'h72);
    i_rtcsr_host.wr(ADDR_EVENT_FLAGS, 8'hFF);
    write_locked <= 1'b1;
    i_rtcsr_host.wr(ADDR_EVENT_FLAGS, 8'h00);
    chk(ADDR_EVENT_FLAGS, 8'h72);
    write_locked <= 1'b0;
    i_rtcsr_host.wr(ADDR_EVENT_FLAGS, 8'h00);
    {calendar_step, alarm_match} <= 2'h3;
    @(posedge sys_clk) calendar_step <= 1'b0;
    chk(ADDR_EVENT_FLAGS, 8'h08);
    i_rtcsr_host.wr(ADDR_EVENT_FLAGS, 8'h00);
    // match still high: a second step must not set the alarm again
    {calendar_step, ext_event_pin} <= 2'h3;
    @(posedge sys_clk) calendar_step <= 1'b0;
    // pin edge needs the two synchroniser stages and the flag flop before the flag sets
    repeat (2) @(posedge sys_clk);
    chk(ADDR_EVENT_FLAGS, 8'h04);
    i_rtcsr_host.wr(ADDR_EVENT_FLAGS, 8'h00);
    tick();
    chk(ADDR_TEMP_INT, 8'hFF);
    chk(ADDR_TEMP_FRAC, 8'hC4);
    i_rtcsr_host.wr(ADDR_TEMP_INT, 8'h12);
    {clock_stopped, temp_measure} <= {1'b1, 12'h550};
    tick();
    chk(ADDR_TEMP_INT, 8'hFF);
    clock_stopped <= 1'b0;
    tick();
    chk(ADDR_TEMP_INT, 8'h55);
    {nvm_abort_low, clock_output_pin_irq_on, backup_switched} <= 3'h7;
    @(posedge sys_clk) {nvm_abort_low, clock_output_pin_irq_on, backup_switched} <= 3'h0;
    chk(ADDR_TEMP_FRAC, 8'h0F);
    backup_switch_select <= BSEL_OFF_B;
    chk(ADDR_TEMP_FRAC, 8'h0E);
    {nvm_busy_in, backup_switch_select} <= {1'b0, BSEL_OFF_A};
    i_rtcsr_host.wr(ADDR_TEMP_FRAC, 8'h00);
    backup_switched <= 1'b1;
    @(posedge sys_clk) backup_switched <= 1'b0;
    chk(ADDR_TEMP_FRAC, 8'h00);
    {supply_below_vlow, clock_output_pin_irq_on} <= 2'h3;
    @(posedge sys_clk) clock_output_pin_irq_on <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK({comp_halt, clock_output_pin_force_low, bus_disable}, 3'h7)
    // bus is off: the read gets no answer and the write must not clear the flag
    chk(ADDR_EVENT_FLAGS, 8'hXX);
    i_rtcsr_host.wr(ADDR_TEMP_FRAC, 8'h00);
    {supply_below_vlow, ext_event_pin} <= 2'h0;
    repeat (6) @(posedge sys_clk);
    chk(ADDR_EVENT_FLAGS, 8'h01);
    chk(ADDR_TEMP_FRAC, 8'h02);
    // second reset in mid-run must drop the low-voltage flag again
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    chk(ADDR_EVENT_FLAGS, EVENT_RESET);
    chk(ADDR_TEMP_INT, 8'h00);
    results();
  end
endmodule
`default_nettype wire

// >>> rtcsr_regs_monitor.sv
// port checker for the status and thermometer registers
`timescale 1ns/1ps
`default_nettype none
module rtcsr_regs_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic supply_below_vlow,
  input wire logic comp_halt,
  input wire logic clock_output_pin_force_low,
  input wire logic bus_disable
);
  import rtcsr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // reads near a supply change are left out: the synchroniser lag makes them ambiguous
  sequence rd_ok; reg_rd && !supply_below_vlow && !bus_disable; endsequence
  sequence low_run; supply_below_vlow [*4]; endsequence
  sequence flag_rd; rd_ok ##0 reg_addr == ADDR_EVENT_FLAGS; endsequence
  // the synchronised supply level seen by the bus equals the pin two samples back
  sequence rd_low; $past(supply_below_vlow, 2) && reg_rd; endsequence
  rd_answer_a : assert property (rd_ok |=> reg_rvalid)
    else $error("read not answered");
  rd_cause_a : assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  rdata_hold_a : assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  flag_top_a : assert property (flag_rd |=> !reg_rdata[7])
    else $error("flag bit 7 set");
  rd_refused_a : assert property (rd_low |=> !reg_rvalid)
    else $error("read answered at low supply");
  halt_tie_a : assert property (comp_halt == bus_disable && comp_halt == clock_output_pin_force_low)
    else $error("halt outputs differ");
  halt_on_a : assert property (low_run |-> comp_halt)
    else $error("halt missing");
  halt_off_a : assert property (!supply_below_vlow [*4] |-> !comp_halt)
    else $error("halt stuck");
  halt_late_a : assert property ($rose(supply_below_vlow) |=> !comp_halt)
    else $error("halt too early");
endmodule
bind rtcsr_regs rtcsr_regs_monitor i_rtcsr_regs_monitor (.*);
`default_nettype wire

// >>> rtcsr_sticky.sv
// sticky flag: hardware set wins over a host clear by writing zero
`timescale 1ns/1ps
`default_nettype none
module rtcsr_sticky (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rst_val,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag
);
  logic flag_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (clr_evt) begin
      flag_ff <= 1'b0;
    end
  end
  assign flag = flag_ff | rst_val;
endmodule
`default_nettype wire

// >>> rtcsr_sync.sv
// two-flop synchroniser for a single level
`timescale 1ns/1ps
`default_nettype none
module rtcsr_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic hold_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      hold_ff <= meta_ff;
    end
  end
  assign dout = hold_ff;
endmodule
`default_nettype wire
